// ### lpsc_map.svh
// Purpose: Offsets, field positions and reset values of the shuttle block.
// Assumes: Included by the shuttle package users only.
// Notes:   Definitions only.
`ifndef LPSC_MAP_SVH
`define LPSC_MAP_SVH

`define LPSC_STATUS_OFF    12'h000
`define LPSC_CTRL_OFF      12'h004

`define LPSC_ST_ON_BIT     0
`define LPSC_ST_NOQS_BIT   1
`define LPSC_ST_STILL_BIT  2
`define LPSC_ST_PLUS_BIT   4
`define LPSC_ST_MINUS_BIT  5

`define LPSC_CTRL_EN_BIT   0
`define LPSC_CTRL_RST      32'h0000_0001

`define LPSC_SYNC_RST      2'h3

`endif

// ### lpsc_pkg.sv
// Purpose: Types shared by the limit position shuttle block.
// Assumes: Nothing beyond a SystemVerilog tool.
// Notes:   Constants live in lpsc_map.svh.
`default_nettype none

package lpsc_pkg;

  typedef enum logic [1:0] {
    LPSC_IDLE,
    LPSC_MOVE,
    LPSC_QSTOP,
    LPSC_REST
  } lpsc_state_t;

  typedef struct packed {
    logic start;
    logic plus_act;
    logic minus_act;
  } lpsc_pins_t;

  typedef struct packed {
    logic motor_on;
    logic no_quick_stop;
    logic dir_minus;
  } lpsc_drive_t;

endpackage : lpsc_pkg

`default_nettype wire

// ### lpsc_top.sv
// Purpose: Limit position shuttle sequencer with an APB status port.
// Assumes: One clock pclk at 200 MHz; asynchronous active-low presetn.
// Notes:   Speed setpoint sign and standstill come from on-clock logic.
//
// Function
// (RULE1) Active end switch reached: request quick stop.
// (RULE2) Resting at an end: start opposite end.
// (RULE3) No end reached: setpoint sign picks direction; code uses it for the first start after reset only, later starts reverse.
// (RULE4) Only start rising edge is a command.
// (RULE5) Start input active high.
// (RULE6) End switch inputs active low.
// (RULE7) Status bit 0 high permits motor on.
// (RULE8) Status bit 1 low requests quick stop.
// (RULE9) Status bit 2 high at standstill; code holds it low while in LPSC_MOVE.
// (RULE10) Status bits 4, 5 show switches actuated.
// (RULE11) Synchronise inputs before edge detection.
`include "lpsc_map.svh"
`default_nettype none

module lpsc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        start_in,
  input  wire logic        plus_end_sw_n,
  input  wire logic        minus_end_sw_n,
  input  wire logic        setpoint_neg,
  input  wire logic        at_standstill,
  output logic             normal_stop_cmd_n,
  output logic             quick_stop_cmd_n,
  output logic             dir_minus
);

  // Register decode is used by both the read and the write path.
  function automatic logic [1:0] lpsc_decode(input logic [11:0] addr);
    logic [1:0] hit;
    hit = 2'h0;
    if (addr == `LPSC_STATUS_OFF) begin
      hit = 2'h1;
    end else if (addr == `LPSC_CTRL_OFF) begin
      hit = 2'h2;
    end
    return hit;
  endfunction : lpsc_decode

  logic [1:0]                s1_q [3];
  lpsc_pkg::lpsc_pins_t      pins;
  logic                      start_d1_q;
  logic                      start_rise;
  lpsc_pkg::lpsc_state_t     state_q;
  lpsc_pkg::lpsc_state_t     state_d;
  logic                      dir_q;
  logic                      dir_d;
  logic                      moved_q;
  logic                      en_q;
  lpsc_pkg::lpsc_drive_t     drv_q;
  lpsc_pkg::lpsc_drive_t     drv_d;
  logic [15:0]               status;
  logic [1:0]                hit;
  logic                      setup;
  logic                      pins_raw [3];

  // Pins come from outside the clock domain, so each passes two flops.
  assign pins_raw[0] = start_in;
  assign pins_raw[1] = plus_end_sw_n;
  assign pins_raw[2] = minus_end_sw_n;

  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_q[i] <= `LPSC_SYNC_RST;
      end else if (ce) begin
        s1_q[i] <= {s1_q[i][0], pins_raw[i]};  // [RULE11]
      end
    end
  end

  // Only the second stage is read; the start synchroniser resets high so
  // that a start held at reset is not taken as a command.
  assign pins.start     = s1_q[0][1];              // [RULE5]
  assign pins.plus_act  = ~s1_q[1][1];             // [RULE6]
  assign pins.minus_act = ~s1_q[2][1];             // [RULE6]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_d1_q <= 1'b1;
    end else if (ce) begin
      start_d1_q <= pins.start;
    end
  end

  assign start_rise = pins.start & ~start_d1_q;    // [RULE4] [RULE11]

  // Sequencer: direction choice and stop requests.
  always_comb begin
    state_d = state_q;
    dir_d   = dir_q;
    case (state_q)
      lpsc_pkg::LPSC_IDLE,
      lpsc_pkg::LPSC_REST: begin
        if (en_q && start_rise) begin            // [RULE4]
          state_d = lpsc_pkg::LPSC_MOVE;
          if (pins.plus_act) begin
            dir_d = 1'b1;                        // [RULE2]
          end else if (pins.minus_act) begin
            dir_d = 1'b0;                        // [RULE2]
          end else if (!moved_q) begin
            dir_d = setpoint_neg;                // [RULE3]
          end else begin
            dir_d = ~dir_q;                      // [RULE2]
          end
        end
      end
      lpsc_pkg::LPSC_MOVE: begin
        if (!en_q) begin
          state_d = lpsc_pkg::LPSC_IDLE;
        end else if (dir_q ? pins.minus_act : pins.plus_act) begin
          state_d = lpsc_pkg::LPSC_QSTOP;        // [RULE1]
        end
      end
      lpsc_pkg::LPSC_QSTOP: begin
        if (at_standstill) begin
          state_d = lpsc_pkg::LPSC_REST;
        end
      end
      default: begin
        state_d = lpsc_pkg::LPSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= lpsc_pkg::LPSC_IDLE;
      dir_q   <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      dir_q   <= dir_d;
    end
  end

  // The power-up direction from the setpoint sign applies only once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      moved_q <= 1'b0;
    end else if (ce && state_d == lpsc_pkg::LPSC_MOVE) begin
      moved_q <= 1'b1;                           // [RULE3]
    end
  end

  // Drive requests follow the next state so they are flops, not gates.
  always_comb begin
    drv_d.motor_on      = (state_d == lpsc_pkg::LPSC_MOVE) ||
                          (state_d == lpsc_pkg::LPSC_QSTOP);  // [RULE7]
    drv_d.no_quick_stop = (state_d != lpsc_pkg::LPSC_QSTOP);  // [RULE1]
    drv_d.dir_minus     = dir_d;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_q <= '{motor_on: 1'b0, no_quick_stop: 1'b1, dir_minus: 1'b0};
    end else if (ce) begin
      drv_q <= drv_d;
    end
  end

  assign normal_stop_cmd_n = drv_q.motor_on;
  assign quick_stop_cmd_n  = drv_q.no_quick_stop;
  assign dir_minus         = drv_q.dir_minus;

  // Status word assembled from flops, synchronised switch levels and the raw at_standstill input.
  always_comb begin
    status                      = 16'h0000;
    status[`LPSC_ST_ON_BIT]     = drv_q.motor_on;          // [RULE7]
    status[`LPSC_ST_NOQS_BIT]   = drv_q.no_quick_stop;     // [RULE8]
    status[`LPSC_ST_STILL_BIT]  = at_standstill &
                                  (state_q != lpsc_pkg::LPSC_MOVE); // [RULE9]
    status[`LPSC_ST_PLUS_BIT]   = pins.plus_act;           // [RULE10]
    status[`LPSC_ST_MINUS_BIT]  = pins.minus_act;          // [RULE10]
  end

  // APB slave: one wait-free access phase, answered from flops.
  assign hit   = lpsc_decode(paddr);
  assign setup = psel & ~penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= setup;
      pslverr <= setup & ((hit == 2'h0) | (pwrite & hit == 2'h1));
      if (setup && !pwrite && hit == 2'h1) begin
        prdata <= {16'h0000, status};
      end else if (setup && !pwrite && hit == 2'h2) begin
        prdata <= {31'h0000_0000, en_q};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Disabling stops the shuttle with a normal stop when it is moving.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'(`LPSC_CTRL_RST);
    end else if (ce && psel && penable && pready && pwrite &&
                 hit == 2'h2) begin
      en_q <= pwdata[`LPSC_CTRL_EN_BIT];
    end
  end

endmodule : lpsc_top

`default_nettype wire

// ### lpsc_monitor.sv
// Purpose: Port assertions for the limit position shuttle.
// Assumes: ce is held high by the bench.
// Notes:   Bound to lpsc_top at the foot of this file.
`default_nettype none

module lpsc_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic start_in,
  input wire logic plus_end_sw_n,
  input wire logic minus_end_sw_n,
  input wire logic at_standstill,
  input wire logic normal_stop_cmd_n,
  input wire logic quick_stop_cmd_n,
  input wire logic dir_minus
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_apb_answer: assert property (psel && !penable && ce |=> pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_end_quick: assert property (
    normal_stop_cmd_n && quick_stop_cmd_n &&
    $fell(dir_minus ? minus_end_sw_n : plus_end_sw_n)
    |-> ##[1:4] !quick_stop_cmd_n) else $error("no quick stop at end");
  chk_quick_hold: assert property (
    !quick_stop_cmd_n && !at_standstill |=> !quick_stop_cmd_n)
    else $error("quick stop dropped early");
  chk_rest_entry: assert property (
    !quick_stop_cmd_n && at_standstill
    |=> quick_stop_cmd_n && !normal_stop_cmd_n) else $error("no rest");
  chk_start_rise: assert property (
    $rose(normal_stop_cmd_n) |-> $past(start_in, 3) && !$past(start_in, 4))
    else $error("motion without start edge");
  chk_rev_dir: assert property (
    $rose(normal_stop_cmd_n) && (plus_end_sw_n ^ minus_end_sw_n)
    |-> dir_minus == !plus_end_sw_n) else $error("wrong reverse");
  chk_dir_steady: assert property (
    normal_stop_cmd_n && $past(normal_stop_cmd_n) |-> $stable(dir_minus))
    else $error("direction changed in motion");

  cov_start: cover property ($rose(normal_stop_cmd_n));
  cov_quick: cover property ($fell(quick_stop_cmd_n));
  cov_error: cover property (pslverr);
endmodule : lpsc_monitor

bind lpsc_top lpsc_monitor lpsc_monitor_inst (.pclk, .presetn, .ce, .psel,
  .penable, .pready, .pslverr, .start_in, .plus_end_sw_n, .minus_end_sw_n,
  .at_standstill, .normal_stop_cmd_n, .quick_stop_cmd_n, .dir_minus);

`default_nettype wire

// ### lpsc_axis_model.sv
// Purpose: Axis with end switches and a speed ramp.
// Assumes: One step of travel per clock while the ramp runs.
// Notes:   The quick ramp is shorter, so overtravel shows it.
`default_nettype none

module lpsc_axis_model #(
  parameter int TRAVEL   = 40,
  parameter int RUN_RAMP = 60,
  parameter int QS_RAMP  = 30
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic normal_stop_cmd_n,
  input  wire logic quick_stop_cmd_n,
  input  wire logic dir_minus,
  output logic      plus_end_sw_n,
  output logic      minus_end_sw_n,
  output logic      at_standstill
);
  int ramp_q;
  int pos_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ramp_q <= 0;
    else if (normal_stop_cmd_n && quick_stop_cmd_n) ramp_q <= RUN_RAMP;
    else if (!quick_stop_cmd_n && ramp_q > QS_RAMP) ramp_q <= QS_RAMP;
    else if (ramp_q != 0) ramp_q <= ramp_q - 1;
  end

  // Reset leaves the axis between both ends.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pos_q <= TRAVEL / 2;
    else if (ramp_q != 0) pos_q <= dir_minus ? pos_q - 1 : pos_q + 1;
  end

  assign plus_end_sw_n  = !(pos_q >= TRAVEL);
  assign minus_end_sw_n = !(pos_q <= 0);
  assign at_standstill  = (ramp_q == 0);
endmodule : lpsc_axis_model

`default_nettype wire

// ### limit_position_shuttle_control_test.sv
// Purpose: Self-checking bench for the shuttle block.
// Assumes: Axis model on the far side; ce tied high.
// Notes:   APB results are checked from a queue of notes.
`default_nettype none

module limit_position_shuttle_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        start_in, setpoint_neg, at_standstill, dir_minus;
  logic        plus_end_sw_n, minus_end_sw_n;
  logic        normal_stop_cmd_n, quick_stop_cmd_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [33:0] e;
  logic [33:0] exp_q[$];
  int          err_total, samples_checked, seed, n;

  lpsc_top lpsc_top_inst (.pclk, .presetn, .ce(1'b1), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .start_in,
    .plus_end_sw_n, .minus_end_sw_n, .setpoint_neg, .at_standstill,
    .normal_stop_cmd_n, .quick_stop_cmd_n, .dir_minus);
  lpsc_axis_model lpsc_axis_model_inst (.pclk, .presetn,
    .normal_stop_cmd_n, .quick_stop_cmd_n, .dir_minus, .plus_end_sw_n,
    .minus_end_sw_n, .at_standstill);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : chk

  task automatic tmo;
    err_total++;
    end_of_test();
  endtask : tmo

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [33:0] x);
    @(posedge pclk);
    exp_q.push_back(x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) tmo();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  always @(negedge pclk) begin
    if (pready === 1'b1) begin
      e = exp_q.pop_front();
      chk({31'h0, pslverr}, {31'h0, e[32]});
      if (e[33]) chk(prdata, e[31:0]);
    end
  end

  // Waits for a given pair of stop outputs.
  task automatic wt(input logic [1:0] v);
    for (n = 0; n < 3000 && {normal_stop_cmd_n, quick_stop_cmd_n} !== v; n++)
      @(negedge pclk);
    if (n >= 3000) tmo();
  endtask : wt

  task automatic go(input logic dm, input logic on);
    @(posedge pclk);
    start_in <= 1'b0;
    repeat (2 + $unsigned($random(seed)) % 6) @(posedge pclk);
    start_in <= 1'b1;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, normal_stop_cmd_n}, {31'h0, on});
    chk({31'h0, dir_minus}, {31'h0, dm});
  endtask : go

  initial begin
    {psel, penable, pwrite, start_in, setpoint_neg, paddr, pwdata} = 49'h0;
    presetn = 1'b0;
    seed = 32'h99b8;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, 34'h2_0000_0006);
    apb(1'b0, 12'h004, 32'h0, 34'h2_0000_0001);
    apb(1'b1, 12'h000, 32'h0, 34'h1_0000_0000);
    apb(1'b0, 12'h008, 32'h0, 34'h3_0000_0000);
    apb(1'b1, 12'h004, $random(seed) & 32'hffff_fffe, 34'h0);
    go(1'b0, 1'b0);
    apb(1'b1, 12'h004, 32'h1, 34'h0);
    setpoint_neg <= 1'b1;
    go(1'b1, 1'b1);
    apb(1'b0, 12'h000, 32'h0, 34'h2_0000_0003);
    wt(2'b10);
    apb(1'b0, 12'h000, 32'h0, 34'h2_0000_0021);
    wt(2'b01);
    apb(1'b0, 12'h000, 32'h0, 34'h2_0000_0026);
    repeat (20) @(negedge pclk);
    chk({31'h0, normal_stop_cmd_n}, 32'h0);
    go(1'b0, 1'b1);
    wt(2'b10);
    wt(2'b01);
    apb(1'b0, 12'h000, 32'h0, 34'h2_0000_0016);
    setpoint_neg <= 1'b0;
    go(1'b1, 1'b1);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, 34'h2_0000_0006);
    go(1'b0, 1'b1);
    end_of_test();
  end
endmodule : limit_position_shuttle_control_test

`default_nettype wire
